// file: bench/dac_cmd_asserts.sv
/* port checker for the command unit.
   bound to the top module; assumes a quiet serial clock between frames. */
`timescale 1ns/1ns
`default_nettype none
module dac_cmd_asserts (
    // clocks and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic SERIAL_CLK_I,
    // link and pins
    input wire logic CHIP_SELECT_N_I,
    input wire logic SERIAL_IN_I,
    input wire logic SERIAL_OUT_O,
    input wire logic CLEAR_N_I,
    input wire logic SHUTDOWN_PERMIT_I,
    // outputs
    input wire logic USER_OUTPUT_PIN_O,
    input wire logic SHUTDOWN_O,
    input wire logic PHASE_RISE_O,
    input wire logic COMMAND_DONE_O,
    input wire logic [3:0][7:0] INPUT_CODE_O,
    input wire logic [3:0][7:0] CONVERTER_CODE_O
);
    // ------------------------------------------------------------------
    // shadow of the shifted word
    // ------------------------------------------------------------------
    logic [11:0] w;
    logic [3:0] p;
    logic d;
    assign p = w[11:8];
    assign d = COMMAND_DONE_O;
    // read only while select is high, so it is stable across domains
    always_ff @(posedge SERIAL_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            w <= 12'h000;
        end else if (!CHIP_SELECT_N_I) begin
            w <= {w[10:0], SERIAL_IN_I};
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    sequence rise_s; $rose(CHIP_SELECT_N_I); endsequence
    sequence exec_s; ##[2:6] d; endsequence
    sel_exec_a: assert property (rise_s |-> exec_s)
        else $error("word not executed");
    load_all_a: assert property (d && p == 4'h8
        |-> CONVERTER_CODE_O == {4{w[7:0]}}) else $error("load all");
    load_input_a: assert property (d && w[8]
        |-> INPUT_CODE_O[w[11:10]] == w[7:0]) else $error("load input");
    update_all_a: assert property (
        d && (w[9:8] == 2'h3 || p == 4'h4 || p == 4'ha || p == 4'he)
        |-> CONVERTER_CODE_O == INPUT_CODE_O)
        else $error("update all");
    nop_keep_a: assert property (d && p == 4'h0
        |-> INPUT_CODE_O == $past(INPUT_CODE_O, 4)
        && CONVERTER_CODE_O == $past(CONVERTER_CODE_O, 4))
        else $error("nop changed codes");
    wake_up_a: assert property (d && (p == 4'h4 || p == 4'h8)
        |-> !SHUTDOWN_O) else $error("no wake");
    shut_permit_a: assert property (d && p == 4'hc |-> SHUTDOWN_O ==
        ($past(SHUTDOWN_PERMIT_I, 4) || $past(SHUTDOWN_O, 4)))
        else $error("shutdown");
    user_pin_a: assert property (d && p[1:0] == 2'h2 && !p[3]
        |-> USER_OUTPUT_PIN_O == w[10]) else $error("user pin");
    phase_cmd_a: assert property (
        d && p[1:0] == 2'h2 && p[3] |-> PHASE_RISE_O == w[10])
        else $error("phase");
    phase_hold_a: assert property ($changed(PHASE_RISE_O)
        |-> ##[0:2] d) else $error("phase moved");
    clear_zero_a: assert property (!CLEAR_N_I
        |-> INPUT_CODE_O == '0 && CONVERTER_CODE_O == '0)
        else $error("clear");
    out_hold_a: assert property (
        CHIP_SELECT_N_I && $past(CHIP_SELECT_N_I)
        && $stable(PHASE_RISE_O) |-> $stable(SERIAL_OUT_O))
        else $error("serial out moved");
endmodule
`default_nettype wire

// file: bench/dac_host_model.sv
/* host serial controller, polarity 0 and phase 0, 64 ns clock.
   assumes send is only called while the select is high. */
`timescale 1ns/1ns
`default_nettype none
module dac_host_model (
    // serial link
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic sdi_o,
    input wire logic sdo_i
);
    logic [11:0] rx;
    logic [11:0] mid;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
        rx = 12'h000;
        mid = 12'h000;
    end
    // far word first, executed word last
    task automatic send(input logic [11:0] far, input logic [11:0] near);
        logic [23:0] f;
        f = {far, near};
        #7 cs_n_o = 1'b0;
        #10;
        for (int i = 0; i < 24; i++) begin
            sdi_o = f[23 - i];
            #31;
            // just before edge i+1 the output shows bit i-13
            if (i >= 13) begin
                rx[24 - i] = sdo_i;
            end
            #1 sclk_o = 1'b1;
            #16;
            // mid-high sample tells the two output phases apart
            if (i >= 12) begin
                mid[23 - i] = sdo_i;
            end
            #16 sclk_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
    endtask
endmodule
`default_nettype wire

// file: bench/tb.sv
/* self-checking bench of the command unit.
   host model on the serial side; pins move on the falling clock edge. */
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk, rst_n, ld_n, clr_n, permit, slow;
    wire logic sclk, cs_n, sdi, sdo, pin, shut, rise, done;
    wire logic [3:0][7:0] inp, conv;
    logic [3:0][7:0] e_in, e_cv;
    logic [7:0] v;
    logic [11:0] f;
    int failures, checked;
    dac_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
        .sdo_i(sdo));
    quad_dac_serial_command_unit u_dut (.CLK_I(clk), .RESET_N_I(rst_n),
        .SERIAL_CLK_I(sclk), .CHIP_SELECT_N_I(cs_n), .SERIAL_IN_I(sdi),
        .SERIAL_OUT_O(sdo), .LOAD_STROBE_N_I(ld_n), .CLEAR_N_I(clr_n),
        .SHUTDOWN_PERMIT_I(permit), .USER_OUTPUT_PIN_O(pin),
        .SHUTDOWN_O(shut), .PHASE_RISE_O(rise), .COMMAND_DONE_O(done),
        .INPUT_CODE_O(inp), .CONVERTER_CODE_O(conv));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    task close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic cmd(input logic [11:0] w, input logic [11:0] far);
        int n;
        n = 0;
        u_host.send(far, w);
        if (w[8]) begin
            e_in[w[11:10]] = w[7:0];
        end
        case (w[11:8])
            4'h8: e_cv = {4{w[7:0]}};
            4'h4, 4'ha, 4'he: e_cv = e_in;
            default: begin
                if (w[9:8] == 2'h3 || (slow && w[8])) begin
                    e_cv = e_in;
                end
            end
        endcase
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (done !== 1'b1) begin
            failures++;
            close_out();
        end
        // select stays high at least four cycles between frames
        cyc(3);
        chk("input codes", inp, e_in);
        chk("converter codes", conv, e_cv);
    endtask
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        ld_n = 1'b1;
        clr_n = 1'b1;
        permit = 1'b0;
        slow = 1'b0;
        failures = 0;
        checked = 0;
        e_in = '0;
        e_cv = '0;
        cyc(6);
        rst_n = 1'b1;
        cyc(4);
        chk("reset codes", inp | conv, 32'h0);
        chk("reset states", {pin, shut, rise}, 3'h0);
        for (int a = 0; a < 4; a++) begin
            v = 8'((a + 1) * 17);
            cmd({2'(a), 2'h1, v}, 12'h000);
        end
        cmd(12'hf55, 12'h000);
        cmd(12'hc00, 12'h000);
        chk("no permit", shut, 1'b0);
        permit = 1'b1;
        cyc(4);
        cmd(12'hcff, 12'h000);
        chk("shutdown", shut, 1'b1);
        cmd(12'h1a7, 12'h000);
        cmd(12'h400, 12'h000);
        chk("wake", shut, 1'b0);
        cmd(12'hcff, 12'h000);
        cmd(12'h8a5, 12'h000);
        chk("load all wake", shut, 1'b0);
        cmd(12'h800, 12'h000);
        chk("load zero", conv, 32'h0);
        cmd(12'h6ff, 12'h000);
        chk("pin high", pin, 1'b1);
        cmd(12'h0ff, 12'h000);
        chk("pin kept", pin, 1'b1);
        cmd(12'h200, 12'h000);
        chk("pin low", pin, 1'b0);
        for (int m = 0; m < 2; m++) begin
            v = m ? 8'h3c : 8'hc3;
            f = m ? 12'h9b6 : 12'h4c9;
            cmd({4'h5, v}, 12'h000);
            cmd(m ? 12'hae0 : 12'hee0, 12'h000);
            chk("phase", rise, m ? 1'b0 : 1'b1);
            cmd(12'h000, f);
            chk("out stream", u_host.rx[11:1], f[11:1]);
            // rising phase shows the new bit while the clock is high
            chk("out phase", m ? u_host.mid[10:0] : u_host.mid,
                m ? f[11:1] : f);
            chk("phase held", rise, m ? 1'b0 : 1'b1);
        end
        ld_n = 1'b0;
        slow = 1'b1;
        e_cv = e_in;
        cyc(4);
        cmd(12'h977, 12'h000);
        chk("transparent", conv[2], 8'h77);
        ld_n = 1'b1;
        slow = 1'b0;
        cyc(4);
        clr_n = 1'b0;
        cyc(3);
        chk("clear", inp | conv, 32'h0);
        clr_n = 1'b1;
        e_in = '0;
        e_cv = '0;
        cyc(4);
        cmd(12'h0ab, 12'h000);
        close_out();
    end
endmodule
bind quad_dac_serial_command_unit dac_cmd_asserts u_chk (.CLK_I,
    .RESET_N_I, .SERIAL_CLK_I, .CHIP_SELECT_N_I, .SERIAL_IN_I,
    .SERIAL_OUT_O, .CLEAR_N_I, .SHUTDOWN_PERMIT_I, .USER_OUTPUT_PIN_O,
    .SHUTDOWN_O, .PHASE_RISE_O, .COMMAND_DONE_O, .INPUT_CODE_O,
    .CONVERTER_CODE_O);
`default_nettype wire

// file: hdl/quad_dac_serial_command_unit.sv
/*
 * command core of a quad 8-bit converter: decodes each 12-bit serial word
 * at the chip-select rising edge and keeps the input and converter code
 * registers, shutdown, the user pin and the serial-output phase.
 * assumes the host keeps the serial clock still while the chip select is
 * high, so the shifted word is stable when the core reads it.
 */
// How it works
// RULE1: msb first: address, control, data; taken on rising edge, select low.
// RULE2: each chip-select rising edge executes the shift register contents.
// RULE3: control 01 loads addressed input; 11 also updates all converters.
// RULE4: 0100 updates all converters and wakes; 1000 also wakes.
// RULE5: 1000 writes the data byte into all four converter registers.
// RULE6: load-all with zero data clears every converter register.
// RULE7: 1100 enters shutdown only while the permit input is high.
// RULE8: 0010 drives the user pin low, 0110 high, held until changed.
// RULE9: 0000 does nothing; the word only passes through.
// RULE10: host: one word per chained device, farthest first, nop for others.
// RULE11: 1110 selects rising-edge serial output and updates all converters.
// RULE12: serial-output phase is held until power-up or the opposite command.
// RULE13: 1010 selects falling-edge serial output and updates all converters.
// RULE14: with load strobe low, input loads pass straight to converters.
// RULE15: clear low resets input and converter registers asynchronously.
// RULE16: falling phase output lags the input stream by 12.5 cycles.
// RULE17: rising phase output lags the input stream by 12 cycles.
// RULE18: after power-up the serial output uses falling-edge phase.
// RULE19: serial output always driven, and holds while chip select is high.
// RULE20: host uses clock polarity 0, phase 0; 1/1 only without readback.
// RULE21: host idles the serial clock low, toggling only for updates.
// RULE22: chained devices share one select; its rise executes all at once.
// RULE23: power-up zeroes all registers and shift register, user pin low.
`timescale 1ns/1ns
`default_nettype none

module quad_dac_serial_command_unit (
    // system clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // serial link
    input wire logic SERIAL_CLK_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic SERIAL_IN_I,
    output logic SERIAL_OUT_O,
    // control pins
    input wire logic LOAD_STROBE_N_I,
    input wire logic CLEAR_N_I,
    input wire logic SHUTDOWN_PERMIT_I,
    // status and codes
    output logic USER_OUTPUT_PIN_O,
    output logic SHUTDOWN_O,
    output logic PHASE_RISE_O,
    output logic COMMAND_DONE_O,
    output logic [3:0][7:0] INPUT_CODE_O,
    output logic [3:0][7:0] CONVERTER_CODE_O
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    serial_link_if link ();

    logic clr_arst_n;
    logic clr_meta;
    logic reg_rst_n;

    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic cs_rise;

    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic strobe_open;

    logic permit_meta;
    logic permit_sync;

    logic cmd_valid;
    logic [dac_cmd_pkg::WORD_BITS-1:0] cmd_word;
    logic [1:0] cmd_addr;
    logic [1:0] cmd_ctrl;
    logic [3:0] cmd_pattern;
    logic [dac_cmd_pkg::DATA_BITS-1:0] cmd_data;

    logic do_load_input;
    logic do_update_all;
    logic do_load_all;
    logic do_wake;
    logic do_shutdown;
    logic do_user_low;
    logic do_user_high;
    logic do_phase_rise;
    logic do_phase_fall;

    logic [3:0][7:0] input_code;
    logic [3:0][7:0] conv_code;
    logic [3:0][7:0] next_input;
    logic [3:0] input_hit;

    logic user_pin;
    logic shutdown;
    logic phase_rise;
    logic done;

    // ------------------------------------------------------------------
    // serial-clock front end
    // ------------------------------------------------------------------
    serial_front u_front (
        .serial_clk_i(SERIAL_CLK_I),
        .chip_select_n_i(CHIP_SELECT_N_I),
        .serial_in_i(SERIAL_IN_I),
        .reset_n_i(RESET_N_I),
        .link(link.front)
    );

    // ------------------------------------------------------------------
    // clear pin: asserts at once, releases on the system clock
    // ------------------------------------------------------------------
    // releasing through two flops keeps the code registers from leaving
    // reset on different edges after a short clear pulse
    assign clr_arst_n = RESET_N_I & CLEAR_N_I;

    always_ff @(posedge CLK_I or negedge clr_arst_n) begin
        if (!clr_arst_n) begin
            clr_meta <= 1'b0;
            reg_rst_n <= 1'b0;
        end else begin
            clr_meta <= 1'b1;
            reg_rst_n <= clr_meta; // [RULE15]
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= CHIP_SELECT_N_I;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            strobe_meta <= 1'b1;
            strobe_sync <= 1'b1;
            strobe_prev <= 1'b1;
        end else begin
            strobe_meta <= LOAD_STROBE_N_I;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            permit_meta <= 1'b0;
            permit_sync <= 1'b0;
        end else begin
            permit_meta <= SHUTDOWN_PERMIT_I;
            permit_sync <= permit_meta;
        end
    end

    assign cs_rise = cs_sync & ~cs_prev;
    // the latch opening copies inputs once; later loads follow below
    assign strobe_open = ~strobe_sync & strobe_prev;

    // ------------------------------------------------------------------
    // word capture at the chip-select rising edge
    // ------------------------------------------------------------------
    // the shift register is frozen while the select is high, so the
    // synchronised select edge qualifies the whole word safely
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            cmd_valid <= 1'b0;
            cmd_word <= dac_cmd_pkg::SHIFT_RESET;
        end else begin
            cmd_valid <= cs_rise; // [RULE2] [RULE22]
            if (cs_rise) begin
                cmd_word <= link.word;
            end
        end
    end

    assign cmd_addr = cmd_word[dac_cmd_pkg::ADDR_MSB:dac_cmd_pkg::ADDR_LSB];
    assign cmd_ctrl = cmd_word[dac_cmd_pkg::CTRL_MSB:dac_cmd_pkg::CTRL_LSB];
    assign cmd_pattern = cmd_word[dac_cmd_pkg::WORD_BITS-1:
                                  dac_cmd_pkg::PATTERN_LSB];
    assign cmd_data = cmd_word[dac_cmd_pkg::DATA_MSB:dac_cmd_pkg::DATA_LSB];

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    always_comb begin
        do_load_input = 1'b0;
        do_update_all = 1'b0;
        do_load_all = 1'b0;
        do_wake = 1'b0;
        do_shutdown = 1'b0;
        do_user_low = 1'b0;
        do_user_high = 1'b0;
        do_phase_rise = 1'b0;
        do_phase_fall = 1'b0;
        if (cmd_valid) begin
            if (cmd_ctrl == dac_cmd_pkg::CTRL_LOAD_INPUT) begin
                do_load_input = 1'b1; // [RULE3]
            end else if (cmd_ctrl == dac_cmd_pkg::CTRL_LOAD_UPDATE) begin
                do_load_input = 1'b1; // [RULE3]
                do_update_all = 1'b1;
            end else begin
                case (cmd_pattern)
                    dac_cmd_pkg::CMD_SW_UPDATE: begin
                        do_update_all = 1'b1; // [RULE4]
                        do_wake = 1'b1;
                    end
                    dac_cmd_pkg::CMD_LOAD_ALL: begin
                        do_load_all = 1'b1; // [RULE5]
                        do_wake = 1'b1; // [RULE4]
                    end
                    dac_cmd_pkg::CMD_SHUTDOWN: begin
                        do_shutdown = permit_sync; // [RULE7]
                    end
                    dac_cmd_pkg::CMD_USER_LOW: begin
                        do_user_low = 1'b1; // [RULE8]
                    end
                    dac_cmd_pkg::CMD_USER_HIGH: begin
                        do_user_high = 1'b1; // [RULE8]
                    end
                    dac_cmd_pkg::CMD_PHASE_RISE: begin
                        do_phase_rise = 1'b1; // [RULE11]
                        do_update_all = 1'b1;
                    end
                    dac_cmd_pkg::CMD_PHASE_FALL: begin
                        do_phase_fall = 1'b1; // [RULE13]
                        do_update_all = 1'b1;
                    end
                    dac_cmd_pkg::CMD_NOP: begin
                        do_update_all = 1'b0; // [RULE9]
                    end
                    default: begin
                        do_update_all = 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // per-channel input and converter registers
    // ------------------------------------------------------------------
    for (genvar ch = 0; ch < dac_cmd_pkg::CHANNELS; ch++) begin : g_chan
        assign input_hit[ch] = do_load_input && (cmd_addr == 2'(ch));
        // an update in the same word sees the freshly loaded value
        assign next_input[ch] = input_hit[ch] ? cmd_data : input_code[ch];

        always_ff @(posedge CLK_I or negedge reg_rst_n) begin
            if (!reg_rst_n) begin
                input_code[ch] <= dac_cmd_pkg::CODE_RESET; // [RULE15]
            end else if (input_hit[ch]) begin
                input_code[ch] <= cmd_data; // [RULE3]
            end
        end

        always_ff @(posedge CLK_I or negedge reg_rst_n) begin
            if (!reg_rst_n) begin
                conv_code[ch] <= dac_cmd_pkg::CODE_RESET; // [RULE23]
            end else if (do_load_all) begin
                // zero data clears the converters like the clear pin, but input codes are kept
                conv_code[ch] <= cmd_data; // [RULE5] [RULE6]
            end else if (do_update_all) begin
                conv_code[ch] <= next_input[ch]; // [RULE3] [RULE4]
            end else if (!strobe_sync &&
                         (input_hit[ch] || strobe_open)) begin
                conv_code[ch] <= next_input[ch]; // [RULE14]
            end
        end
    end

    // ------------------------------------------------------------------
    // shutdown, user pin and serial-output phase
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            shutdown <= dac_cmd_pkg::SHUTDOWN_RESET;
        end else if (do_shutdown) begin
            shutdown <= 1'b1; // [RULE7]
        end else if (do_wake) begin
            shutdown <= 1'b0; // [RULE4]
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            user_pin <= dac_cmd_pkg::USER_PIN_RESET; // [RULE23]
        end else if (do_user_high) begin
            user_pin <= 1'b1; // [RULE8]
        end else if (do_user_low) begin
            user_pin <= 1'b0; // [RULE8]
        end
    end

    // the clear pin leaves the phase alone: only power-up or a command
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            phase_rise <= dac_cmd_pkg::PHASE_RISE_RESET; // [RULE18]
        end else if (do_phase_rise) begin
            phase_rise <= 1'b1; // [RULE11] [RULE12]
        end else if (do_phase_fall) begin
            phase_rise <= 1'b0; // [RULE13] [RULE12]
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            done <= 1'b0;
        end else begin
            done <= cmd_valid;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // phase only changes while the select is high and both stages are
    // frozen, so this select never glitches inside a frame
    assign SERIAL_OUT_O = phase_rise ? link.out_rise
                                     : link.out_fall; // [RULE19]
    assign USER_OUTPUT_PIN_O = user_pin;
    assign SHUTDOWN_O = shutdown;
    assign PHASE_RISE_O = phase_rise;
    assign COMMAND_DONE_O = done;
    assign INPUT_CODE_O = input_code;
    assign CONVERTER_CODE_O = conv_code;

endmodule

`default_nettype wire

// file: hdl/serial_front.sv
/*
 * serial shift register and serial-output stages, clocked by the host's
 * serial clock. assumes the chip select meets setup to the serial clock,
 * which the host guarantees, so it is used as a plain enable here.
 */
`timescale 1ns/1ns
`default_nettype none

module serial_front (
    // serial link
    input wire logic serial_clk_i,
    input wire logic chip_select_n_i,
    input wire logic serial_in_i,
    // reset
    input wire logic reset_n_i,
    // towards the core
    serial_link_if.front link
);

    logic [dac_cmd_pkg::WORD_BITS-1:0] shift_reg;
    logic out_rise;
    logic out_fall;

    // ------------------------------------------------------------------
    // shift in, msb first, on rising serial clock
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_reg <= dac_cmd_pkg::SHIFT_RESET; // [RULE23]
        end else if (!chip_select_n_i) begin
            shift_reg <= {shift_reg[dac_cmd_pkg::WORD_BITS-2:0],
                          serial_in_i}; // [RULE1]
        end
    end

    // ------------------------------------------------------------------
    // output stages: both hold while the chip select is high
    // ------------------------------------------------------------------
    // rising stage takes the bit leaving the register: twelve cycles
    always_ff @(posedge serial_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_rise <= 1'b0;
        end else if (!chip_select_n_i) begin
            out_rise <= shift_reg[dac_cmd_pkg::WORD_BITS-1]; // [RULE17]
        end
    end

    // falling stage re-times it half a cycle later: twelve and a half
    always_ff @(negedge serial_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_fall <= 1'b0;
        end else if (!chip_select_n_i) begin
            out_fall <= out_rise; // [RULE16]
        end
    end

    assign link.word = shift_reg;
    assign link.out_rise = out_rise;
    assign link.out_fall = out_fall;

endmodule

`default_nettype wire

// file: include/dac_cmd_pkg.sv
/*
 * constants shared by the serial front end and the command core of the
 * quad converter command unit: word layout, command patterns, reset values.
 * assumes nothing of its surroundings.
 */
package dac_cmd_pkg;

    // ------------------------------------------------------------------
    // word layout
    // ------------------------------------------------------------------
    localparam int WORD_BITS = 12;
    localparam int DATA_BITS = 8;
    localparam int CHANNELS = 4;
    localparam int ADDR_MSB = 11;
    localparam int ADDR_LSB = 10;
    localparam int CTRL_MSB = 9;
    localparam int CTRL_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int DATA_LSB = 0;
    localparam int PATTERN_LSB = 8;

    // ------------------------------------------------------------------
    // control field values for per-channel loads
    // ------------------------------------------------------------------
    localparam logic [1:0] CTRL_LOAD_INPUT = 2'h1;
    localparam logic [1:0] CTRL_LOAD_UPDATE = 2'h3;

    // ------------------------------------------------------------------
    // address plus control patterns of the global commands
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_USER_LOW = 4'h2,
        CMD_SW_UPDATE = 4'h4,
        CMD_USER_HIGH = 4'h6,
        CMD_LOAD_ALL = 4'h8,
        CMD_PHASE_FALL = 4'ha,
        CMD_SHUTDOWN = 4'hc,
        CMD_PHASE_RISE = 4'he
    } cmd_t;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [WORD_BITS-1:0] SHIFT_RESET = 12'h000;
    localparam logic [DATA_BITS-1:0] CODE_RESET = 8'h00;
    localparam logic USER_PIN_RESET = 1'b0;
    localparam logic SHUTDOWN_RESET = 1'b0;
    localparam logic PHASE_RISE_RESET = 1'b0;

endpackage

// file: include/serial_link_if.sv
/*
 * bundle between the serial-clock front end and the command core.
 * assumes the word only changes while the chip select is low.
 */
`timescale 1ns/1ns
`default_nettype none

interface serial_link_if;
    logic [dac_cmd_pkg::WORD_BITS-1:0] word;
    logic out_rise;
    logic out_fall;

    modport front (
        output word,
        output out_rise,
        output out_fall
    );

    modport core (
        input word,
        input out_rise,
        input out_fall
    );
endinterface

`default_nettype wire
